// ==== logic/chg_pkg.sv ====
// Constants for the charger control register bank.
// Assumes a single 100 MHz clock domain and an I2C slave in front of it.
package chg_pkg;
  localparam logic [6:0] I2C_ADDR        = 7'h6A;
  localparam logic [7:0] REG_CTRL        = 8'h05;
  localparam logic [7:0] REG_FAST        = 8'h06;
  localparam logic [7:0] REG_INLIM       = 8'h07;
  localparam int         MON_OFF_BIT     = 1;
  localparam int         STANDBY_BIT     = 0;
  localparam int         RESTART_BIT     = 6;
  localparam logic [7:0] CTRL_RST        = 8'h00;
  localparam logic [4:0] CC_RST          = 5'h0A;   // 500mA
  localparam logic [2:0] TMR_RST         = 3'h2;    // 5 hours
  localparam logic [5:0] IL_RST          = 6'h14;   // 500mA
  localparam logic       RESTART_RST     = 1'b0;
  localparam logic [7:0] FAST_RST        = {TMR_RST, CC_RST};
  localparam logic [7:0] INLIM_RST       = {1'b0, RESTART_RST, IL_RST};
  localparam logic [10:0] CC_MIN_MA      = 11'h0FA;
  localparam logic [4:0] CC_FLOOR_CODE   = 5'h05;
  localparam logic [10:0] CC_STEP_MA     = 11'h032;
  localparam logic [10:0] IL_MIN_MA      = 11'h064;
  localparam logic [10:0] IL_BASE_MA     = 11'h0FA;
  localparam logic [5:0] IL_BASE_CODE    = 6'h0A;
  localparam logic [10:0] IL_STEP_MA     = 11'h019;
  localparam logic [5:0] IL_OFF_CODE     = 6'h3F;
  localparam logic [5:0] IL_MAX_CODE     = 6'h3C;
  localparam logic [3:0] TMR_BASE_HRS    = 4'h3;
  localparam logic [10:0] TRIP_PCT       = 11'h05F;
  localparam logic [10:0] PCT_DIV        = 11'h064;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_ADDR  = 3'b001,
    S_REGA  = 3'b011,
    S_WDATA = 3'b010,
    S_RDATA = 3'b110,
    S_SKIP  = 3'b111
  } i2c_state_t;

  // 250mA floor then 50mA per code
  function automatic logic [10:0] ccMilliamp(input logic [4:0] code);
    logic [10:0] steps;
    steps = 11'h000;
    if (code > CC_FLOOR_CODE)
      steps = 11'(code - CC_FLOOR_CODE);
    return 11'(CC_MIN_MA + 11'(steps * CC_STEP_MA));
  endfunction

  // 0 disables, else 3 + code hours
  function automatic logic [3:0] timerHours(input logic [2:0] code);
    return (code == 3'h0) ? 4'h0 : 4'(TMR_BASE_HRS + 4'(code));
  endfunction

  // Unlisted codes 61 and 62 clamp to the top step
  function automatic logic [10:0] ilMilliamp(input logic [5:0] code);
    logic [5:0] c;
    c = (code > IL_MAX_CODE) ? IL_MAX_CODE : code;
    if (c < IL_BASE_CODE)
      return IL_MIN_MA;
    return 11'(IL_BASE_MA + 11'(11'(c - IL_BASE_CODE) * IL_STEP_MA));
  endfunction
endpackage

// ==== logic/i2c_edge.sv ====
// Input conditioner for SCL/SDA: two-stage synchroniser and edge detect.
// Assumes pins are already clean levels sampled on ref_clk.
`timescale 1ns/1ps
module i2c_edge
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // Raw pin
  input  wire logic pinIn,
  // Conditioned outputs
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic [1:0] syncFf;
  logic [1:0] nxt_syncFf;
  logic       lastFf;
  logic       nxt_lastFf;

  always_comb
  begin
    nxt_syncFf = {syncFf[0], pinIn};
    nxt_lastFf = syncFf[1];
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      syncFf <= 2'h3;
      lastFf <= 1'b1;
    end
    else
    begin
      syncFf <= nxt_syncFf;
      lastFf <= nxt_lastFf;
    end
  end

  assign level = syncFf[1];
  assign rise  = syncFf[1] & ~lastFf;
  assign fall  = ~syncFf[1] & lastFf;
endmodule // i2c_edge

// ==== logic/current_decode.sv ====
// Registered decode of the current and timer codes into physical targets.
// Assumes codes are stable register outputs.
`timescale 1ns/1ps
module current_decode
  import chg_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Codes
  input  wire logic [4:0]  ccCode,
  input  wire logic [2:0]  tmrCode,
  input  wire logic [5:0]  ilCode,
  // Targets
  output logic [10:0]      ccMa,
  output logic [3:0]       tmrHours,
  output logic [10:0]      ilMa,
  output logic [10:0]      ilTripMa,
  output logic             ilOff
);
  logic [10:0] nxt_ccMa;
  logic [3:0]  nxt_tmrHours;
  logic [10:0] nxt_ilMa;
  logic [10:0] nxt_ilTripMa;
  logic        nxt_ilOff;
  logic [21:0] prod;

  always_comb
  begin
    nxt_ccMa     = ccMilliamp(ccCode);
    nxt_tmrHours = timerHours(tmrCode);
    nxt_ilMa     = ilMilliamp(ilCode);
    nxt_ilOff    = (ilCode == IL_OFF_CODE);
    prod         = nxt_ilMa * TRIP_PCT;
    nxt_ilTripMa = 11'(prod / 22'(PCT_DIV));
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ccMa     <= 11'h000;
      tmrHours <= 4'h0;
      ilMa     <= 11'h000;
      ilTripMa <= 11'h000;
      ilOff    <= 1'b0;
    end
    else
    begin
      ccMa     <= nxt_ccMa;
      tmrHours <= nxt_tmrHours;
      ilMa     <= nxt_ilMa;
      ilTripMa <= nxt_ilTripMa;
      ilOff    <= nxt_ilOff;
    end
  end
endmodule // current_decode

// ==== logic/charger_control_registers.sv ====
// I2C slave and three charger control registers with decoded targets.
// Assumes SCL/SDA levels sampled on ref_clk, SCL well below clock/8.
`timescale 1ns/1ps
module charger_control_registers
  import chg_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Register reset sources
  input  wire logic        standby_supply_valid,
  input  wire logic        safe_out_power_good,
  // I2C pins, open drain
  input  wire logic        scl,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  // Charger state from the analog side
  input  wire logic        chargeEnable,
  input  wire logic        converterOn,
  input  wire logic        charger_write_protect,
  // Controls
  output logic             input_voltage_monitor_off,
  output logic             usb_low_power_standby,
  output logic             recharge_threshold_select,
  output logic [10:0]      chargeLimitMa,
  output logic [3:0]       fastTimerHours,
  output logic [10:0]      inputLimitMa,
  output logic [10:0]      input_limit_trip,
  output logic             inputLimitOff
);
  // ****************************************
  // Pin conditioning
  // ****************************************
  logic sclLvl, sclRise, sclFall, sdaLvl, sdaRise, sdaFall;

  i2c_edge uSclEdge (.ref_clk(ref_clk), .rst(rst), .pinIn(scl),
                     .level(sclLvl), .rise(sclRise), .fall(sclFall));
  i2c_edge uSdaEdge (.ref_clk(ref_clk), .rst(rst), .pinIn(sdaIn),
                     .level(sdaLvl), .rise(sdaRise), .fall(sdaFall));

  wire startCond = sdaFall & sclLvl;
  wire stopCond  = sdaRise & sclLvl;

  // ****************************************
  // Register-reset event
  // ****************************************
  logic sfoLast_ff, nxt_sfoLast_ff;
  logic regClear;
  always_comb
  begin
    nxt_sfoLast_ff = safe_out_power_good;
    regClear       = ~standby_supply_valid | (safe_out_power_good & ~sfoLast_ff);
  end
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      sfoLast_ff <= 1'b0;
    else
      sfoLast_ff <= nxt_sfoLast_ff;
  end

  // ****************************************
  // I2C slave state machine
  // ****************************************
  i2c_state_t state_ff, nxt_state_ff;
  logic [7:0] shift_ff, nxt_shift_ff;
  logic [3:0] bitCnt_ff, nxt_bitCnt_ff;
  logic [7:0] ptr_ff, nxt_ptr_ff;
  logic       ack_ff, nxt_ack_ff;     // Drive low during ninth bit
  logic       isRead_ff, nxt_isRead_ff;
  logic       drvBit_ff, nxt_drvBit_ff;
  logic       sdaOut_ff, nxt_sdaOut_ff;
  logic       sdaOe_ff, nxt_sdaOe_ff;
  logic       wrStb;
  logic [7:0] wrAddr, wrData;

  logic [1:0] ctrl_ff, nxt_ctrl_ff;
  logic [7:0] fast_ff, nxt_fast_ff;
  logic [6:0] inlim_ff, nxt_inlim_ff;

  function automatic logic [7:0] readReg(input logic [7:0] a);
    unique case (a)
      REG_CTRL:  return {6'h00, ctrl_ff};
      REG_FAST:  return fast_ff;
      REG_INLIM: return {1'b0, inlim_ff};
      default:   return 8'h00;
    endcase
  endfunction

  always_comb
  begin
    nxt_state_ff  = state_ff;
    nxt_shift_ff  = shift_ff;
    nxt_bitCnt_ff = bitCnt_ff;
    nxt_ptr_ff    = ptr_ff;
    nxt_ack_ff    = ack_ff;
    nxt_isRead_ff = isRead_ff;
    nxt_drvBit_ff = drvBit_ff;
    wrStb         = 1'b0;
    wrAddr        = ptr_ff;
    wrData        = shift_ff;
    if (startCond)
    begin
      nxt_state_ff  = S_ADDR;
      nxt_bitCnt_ff = 4'h0;
      nxt_ack_ff    = 1'b0;
      nxt_drvBit_ff = 1'b0;
    end
    else if (stopCond)
    begin
      nxt_state_ff  = S_IDLE;
      nxt_ack_ff    = 1'b0;
      nxt_drvBit_ff = 1'b0;
    end
    else if (sclRise && state_ff != S_IDLE && state_ff != S_SKIP && bitCnt_ff < 4'h8)
    begin
      nxt_shift_ff  = {shift_ff[6:0], sdaLvl};
      nxt_bitCnt_ff = 4'(bitCnt_ff + 4'h1);
    end
    else if (sclRise && bitCnt_ff == 4'h8 && state_ff == S_RDATA)
      nxt_bitCnt_ff = 4'h9;   // Ninth clock seen; master ack is read at the next SCL fall, NACK ends the read
    else if (sclFall && state_ff != S_IDLE && state_ff != S_SKIP)
    begin
      nxt_ack_ff    = 1'b0;
      nxt_drvBit_ff = 1'b0;
      if (bitCnt_ff == 4'h8 && state_ff != S_RDATA)
      begin
        unique case (state_ff)
          S_ADDR:
          begin
            if (shift_ff[7:1] == I2C_ADDR)
            begin
              nxt_ack_ff    = 1'b1;
              nxt_isRead_ff = shift_ff[0];
            end
            else
              nxt_state_ff = S_SKIP;
          end
          S_REGA:
          begin
            nxt_ack_ff = 1'b1;
            nxt_ptr_ff = shift_ff;
          end
          default:
          begin
            nxt_ack_ff = 1'b1;
            wrStb      = 1'b1;
            nxt_ptr_ff = 8'(ptr_ff + 8'h01);
          end
        endcase
        nxt_bitCnt_ff = 4'h9;
      end
      else if (bitCnt_ff == 4'h9)
      begin
        nxt_bitCnt_ff = 4'h0;
        if (state_ff == S_ADDR)
          nxt_state_ff = isRead_ff ? S_RDATA : S_REGA;
        else if (state_ff == S_REGA)
          nxt_state_ff = S_WDATA;
        else if (state_ff == S_RDATA && sdaLvl)
          nxt_state_ff = S_SKIP;
        if (nxt_state_ff == S_RDATA)
        begin
          nxt_shift_ff  = readReg(ptr_ff);
          nxt_drvBit_ff = 1'b1;
          nxt_ptr_ff    = 8'(ptr_ff + 8'h01);
        end
      end
      else if (state_ff == S_RDATA && bitCnt_ff < 4'h8)
        nxt_drvBit_ff = 1'b1;
      if (state_ff == S_RDATA && bitCnt_ff == 4'h8)
        nxt_drvBit_ff = 1'b0;
    end
    // Read bits shift out MSB first; the shift register doubles as output.
    // The shift moves on SCL rise, so the drive is only updated on SCL fall
    // (or START/STOP); otherwise SDA would move while SCL is high.
    nxt_sdaOe_ff  = sdaOe_ff;
    if (startCond || stopCond || sclFall)
      nxt_sdaOe_ff = nxt_ack_ff | (nxt_drvBit_ff & ~nxt_shift_ff[7]);
    nxt_sdaOut_ff = 1'b0;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_ff  <= S_IDLE;
      shift_ff  <= 8'h00;
      bitCnt_ff <= 4'h0;
      ptr_ff    <= 8'h00;
      ack_ff    <= 1'b0;
      isRead_ff <= 1'b0;
      drvBit_ff <= 1'b0;
      sdaOut_ff <= 1'b0;
      sdaOe_ff  <= 1'b0;
    end
    else
    begin
      state_ff  <= nxt_state_ff;
      shift_ff  <= nxt_shift_ff;
      bitCnt_ff <= nxt_bitCnt_ff;
      ptr_ff    <= nxt_ptr_ff;
      ack_ff    <= nxt_ack_ff;
      isRead_ff <= nxt_isRead_ff;
      drvBit_ff <= nxt_drvBit_ff;
      sdaOut_ff <= nxt_sdaOut_ff;
      sdaOe_ff  <= nxt_sdaOe_ff;
    end
  end

  assign sdaOut = sdaOut_ff;
  assign sdaOe  = sdaOe_ff;

  // ****************************************
  // Register file
  // ****************************************
  always_comb
  begin
    nxt_ctrl_ff  = ctrl_ff;
    nxt_fast_ff  = fast_ff;
    nxt_inlim_ff = inlim_ff;
    if (regClear)
    begin
      nxt_ctrl_ff  = CTRL_RST[1:0];
      nxt_fast_ff  = FAST_RST;
      nxt_inlim_ff = INLIM_RST[6:0];
    end
    else if (wrStb)
    begin
      if (wrAddr == REG_CTRL)
        nxt_ctrl_ff = wrData[1:0];
      // Protected registers ignore I2C writes while locked; regClear still resets them
      if (wrAddr == REG_FAST && !charger_write_protect)
        nxt_fast_ff = wrData;
      if (wrAddr == REG_INLIM && !charger_write_protect)
        nxt_inlim_ff = wrData[6:0];
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_ff  <= CTRL_RST[1:0];
      fast_ff  <= FAST_RST;
      inlim_ff <= INLIM_RST[6:0];
    end
    else
    begin
      ctrl_ff  <= nxt_ctrl_ff;
      fast_ff  <= nxt_fast_ff;
      inlim_ff <= nxt_inlim_ff;
    end
  end

  // ****************************************
  // Control outputs
  // ****************************************
  logic [10:0] ccMa, ilMa, ilTrip;
  logic        ilOffD;
  logic [3:0]  tmrH;

  current_decode uDecode (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .ccCode   (fast_ff[4:0]),
    .tmrCode  (fast_ff[7:5]),
    .ilCode   (inlim_ff[5:0]),
    .ccMa     (ccMa),
    .tmrHours (tmrH),
    .ilMa     (ilMa),
    .ilTripMa (ilTrip),
    .ilOff    (ilOffD)
  );

  logic        monOff_ff, standby_ff, restart_ff, ilOff_ff;
  logic [10:0] chgMa_ff, inMa_ff, trip_ff;
  logic [3:0]  tmr_ff;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      monOff_ff  <= 1'b0;
      standby_ff <= 1'b0;
      restart_ff <= 1'b0;
      ilOff_ff   <= 1'b0;
      chgMa_ff   <= 11'h000;
      inMa_ff    <= 11'h000;
      trip_ff    <= 11'h000;
      tmr_ff     <= 4'h0;
    end
    else
    begin
      monOff_ff  <= ctrl_ff[MON_OFF_BIT];
      standby_ff <= ctrl_ff[STANDBY_BIT];
      restart_ff <= inlim_ff[RESTART_BIT];
      chgMa_ff   <= chargeEnable ? ccMa : 11'h000;
      tmr_ff     <= tmrH;
      inMa_ff    <= converterOn ? ilMa : 11'h000;
      trip_ff    <= converterOn ? ilTrip : 11'h000;
      ilOff_ff   <= ilOffD;
    end
  end

  assign input_voltage_monitor_off = monOff_ff;
  assign usb_low_power_standby     = standby_ff;
  assign recharge_threshold_select = restart_ff;
  assign chargeLimitMa             = chgMa_ff;
  assign fastTimerHours            = tmr_ff;
  assign inputLimitMa              = inMa_ff;
  assign input_limit_trip          = trip_ff;
  assign inputLimitOff             = ilOff_ff;

  // ****************************************
  // Checks
  // ****************************************
  a_ctrl_defaults: assert property (@(posedge ref_clk) disable iff (rst)
    regClear |=> ctrl_ff == 2'h0 && fast_ff == FAST_RST)
    else $error("registers not defaulted");
  a_protect_hold: assert property (@(posedge ref_clk) disable iff (rst)
    charger_write_protect && !regClear |=> $stable(fast_ff))
    else $error("protected register changed");
  a_monitor_follow: assert property (@(posedge ref_clk) disable iff (rst)
    ##1 input_voltage_monitor_off == $past(ctrl_ff[1]))
    else $error("monitor control mismatch");
  a_standby_follow: assert property (@(posedge ref_clk) disable iff (rst)
    ##1 usb_low_power_standby == $past(ctrl_ff[0]))
    else $error("standby control mismatch");
  a_charge_gate: assert property (@(posedge ref_clk) disable iff (rst)
    !chargeEnable |=> chargeLimitMa == 11'h000)
    else $error("charge limit while disabled");
  a_cc_floor: assert property (@(posedge ref_clk) disable iff (rst)
    (fast_ff[4:0] <= 5'h05) ##1 chargeEnable |=> chargeLimitMa == 11'h0FA)
    else $error("charge floor wrong");
  a_timer_off: assert property (@(posedge ref_clk) disable iff (rst)
    fast_ff[7:5] == 3'h0 && $stable(fast_ff) |=> ##1 fastTimerHours == 4'h0)
    else $error("timer not disabled");
  a_trip_below: assert property (@(posedge ref_clk) disable iff (rst)
    input_limit_trip <= inputLimitMa)
    else $error("trip above target");
  a_ack_addr: assert property (@(posedge ref_clk) disable iff (rst)
    state_ff == S_ADDR && sclFall && bitCnt_ff == 4'h8 && shift_ff[7:1] != I2C_ADDR
      |=> !sdaOe)
    else $error("acked wrong address");
  a_sda_quiet: assert property (@(posedge ref_clk) disable iff (rst)
    !(startCond || stopCond || sclFall) |=> $stable(sdaOe))
    else $error("SDA drive moved outside SCL low");
  c_write_fast: cover property (@(posedge ref_clk) wrStb && wrAddr == REG_FAST);
  c_read: cover property (@(posedge ref_clk) state_ff == S_RDATA);
  c_sfo_reset: cover property (@(posedge ref_clk) regClear && standby_supply_valid);
endmodule // charger_control_registers

// ==== sim/i2c_host_model.sv ====
// Behavioural I2C host that reaches the charger control registers.
// Assumes SDA is resolved outside with a pull-up; drives pins at ref_clk falls.
`timescale 1ns/1ps
module i2c_host_model
#(
  parameter int HALF_CYC = 8
)
(
  // Clock
  input  wire logic ref_clk,
  // Bus
  output logic      scl,
  output logic      sdaLow,
  input  wire logic sdaLine
);
  // ************************************************************
  // Bit and byte sequencing
  // ************************************************************
  initial
  begin
    scl    = 1'b1;
    sdaLow = 1'b0;
  end

  task automatic waitPhase();
    repeat (HALF_CYC) @(negedge ref_clk);
  endtask

  // Also serves as repeated start from a low SCL
  task automatic startCond();
    sdaLow = 1'b0;
    waitPhase();
    scl = 1'b1;
    waitPhase();
    sdaLow = 1'b1;
    waitPhase();
    scl = 1'b0;
  endtask

  task automatic stopCond();
    sdaLow = 1'b1;
    waitPhase();
    scl = 1'b1;
    waitPhase();
    sdaLow = 1'b0;
    waitPhase();
  endtask

  // Short hold after the fall keeps SDA moves clear of the SCL edge
  task automatic bitXfer(input logic b, output logic r);
    sdaLow = ~b;
    waitPhase();
    scl = 1'b1;
    waitPhase();
    r = sdaLine;
    scl = 1'b0;
    repeat (2) @(negedge ref_clk);
  endtask

  task automatic byteOut(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitXfer(d[i], r);
    bitXfer(1'b1, r);
    ack = ~r;
  endtask

  task automatic byteIn(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bitXfer(1'b1, r);
      d[i] = r;
    end
    bitXfer(last, r);
  endtask

  task automatic regWrite(input logic [6:0] dev, input logic [7:0] ra,
                          input logic [7:0] data, output logic ok);
    logic a0;
    logic a1;
    logic a2;
    startCond();
    byteOut({dev, 1'b0}, a0);
    byteOut(ra, a1);
    byteOut(data, a2);
    stopCond();
    ok = a0 & a1 & a2;
  endtask

  task automatic regRead(input logic [6:0] dev, input logic [7:0] ra,
                         output logic [7:0] data, output logic ok);
    logic a0;
    logic a1;
    logic a2;
    startCond();
    byteOut({dev, 1'b0}, a0);
    byteOut(ra, a1);
    startCond();
    byteOut({dev, 1'b1}, a2);
    byteIn(1'b1, data);
    stopCond();
    ok = a0 & a1 & a2;
  endtask
endmodule // i2c_host_model

// ==== sim/testbench.sv ====
// Self-checking bench for the charger control register bank.
// Assumes the I2C host model and an SDA pull-up resolved here.
`timescale 1ns/1ps
module testbench
  import chg_pkg::*;
;
  logic        ref_clk;
  logic        rst;
  logic        supplyValid;
  logic        safeGood;
  logic        chargeEnable;
  logic        converterOn;
  logic        writeLock;
  logic        scl;
  logic        sdaLow;
  logic        sdaLine;
  logic        sdaOut;
  logic        sdaOe;
  logic        monOff;
  logic        standby;
  logic        restartSel;
  logic [10:0] chargeMa;
  logic [3:0]  timerHrs;
  logic [10:0] inputMa;
  logic [10:0] tripMa;
  logic        limitOff;
  logic        ok;
  logic [7:0]  rdVal;
  int          expMa;
  int          errTotal = 0;
  int          comparisons = 0;

  // Open drain with pull-up
  assign sdaLine = ~(sdaLow | sdaOe);

  charger_control_registers i_dut (.ref_clk(ref_clk), .rst(rst),
    .standby_supply_valid(supplyValid), .safe_out_power_good(safeGood),
    .scl(scl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .chargeEnable(chargeEnable), .converterOn(converterOn),
    .charger_write_protect(writeLock), .input_voltage_monitor_off(monOff),
    .usb_low_power_standby(standby), .recharge_threshold_select(restartSel),
    .chargeLimitMa(chargeMa), .fastTimerHours(timerHrs), .inputLimitMa(inputMa),
    .input_limit_trip(tripMa), .inputLimitOff(limitOff));

  i2c_host_model i_host (.ref_clk(ref_clk), .scl(scl), .sdaLow(sdaLow),
    .sdaLine(sdaLine));

  // ************************************************************
  // Clock, compares and register access
  // ************************************************************
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic end_of_test();
    if (errTotal == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errTotal++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chkNum(input logic [10:0] got, input logic [10:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errTotal++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] ra, input logic [7:0] d);
    i_host.regWrite(I2C_ADDR, ra, d, ok);
    chkNum(11'(ok), 11'h001);
  endtask

  task automatic rdChk(input logic [7:0] ra, input logic [7:0] exp);
    i_host.regRead(I2C_ADDR, ra, rdVal, ok);
    chkNum(11'(ok), 11'h001);
    chkByte(rdVal, exp);
  endtask

  // Hang guard
  initial
  begin
    repeat (100000) @(posedge ref_clk);
    errTotal++;
    end_of_test();
  end

  // ************************************************************
  // Scenarios
  // ************************************************************
  initial
  begin
    rst          = 1'b1;
    supplyValid  = 1'b1;
    safeGood     = 1'b0;
    chargeEnable = 1'b1;
    converterOn  = 1'b1;
    writeLock    = 1'b0;
    repeat (8) @(negedge ref_clk);
    rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    rdChk(REG_CTRL, 8'h00);
    rdChk(REG_FAST, 8'h4A);
    rdChk(REG_INLIM, 8'h14);
    chkNum(chargeMa, 11'h1F4);
    chkNum(11'(timerHrs), 11'h005);
    chkNum(inputMa, 11'h1F4);
    i_host.regWrite(7'h6B, REG_CTRL, 8'h03, ok);
    chkNum(11'(ok), 11'h000);
    rdChk(REG_CTRL, 8'h00);
    for (int k = 0; k < 4; k++)
    begin
      wr(REG_CTRL, 8'hFC | 8'(k));
      rdChk(REG_CTRL, 8'(k));
      chkNum(11'(monOff), 11'(k >> 1));
      chkNum(11'(standby), 11'(k & 1));
    end
    for (int c = 0; c < 32; c++)
    begin
      wr(REG_FAST, {c[2:0], c[4:0]});
      expMa = (c <= 5'h05) ? 32'h0FA : 32'h0FA + (c - 5'h05) * 32'h032;
      chkNum(chargeMa, 11'(expMa));
      expMa = (c[2:0] == 3'h0) ? 32'h0 : int'(c[2:0]) + 32'h3;
      chkNum(11'(timerHrs), 11'(expMa));
    end
    for (int c = 0; c < 64; c++)
    begin
      wr(REG_INLIM, {1'b0, c[0], c[5:0]});
      expMa = (c < 6'h0A) ? 32'h064 : (c >= 6'h3C) ? 32'h5DC
            : 32'h0FA + (c - 6'h0A) * 32'h019;
      chkNum(11'(restartSel), 11'(c & 1));
      chkNum(11'(limitOff), 11'(c == 6'h3F));
      if (c != 6'h3F)
      begin
        chkNum(inputMa, 11'(expMa));
        chkNum(tripMa, 11'(expMa * 32'h05F / 32'h064));
      end
    end
    chargeEnable = 1'b0;
    converterOn  = 1'b0;
    repeat (4) @(negedge ref_clk);
    chkNum(chargeMa, 11'h000);
    chkNum(inputMa, 11'h000);
    chkNum(tripMa, 11'h000);
    chargeEnable = 1'b1;
    converterOn  = 1'b1;
    writeLock    = 1'b1;
    wr(REG_FAST, 8'h00);
    wr(REG_INLIM, 8'h00);
    wr(REG_CTRL, 8'h02);
    rdChk(REG_FAST, 8'hFF);
    rdChk(REG_INLIM, 8'h7F);
    rdChk(REG_CTRL, 8'h02);
    writeLock = 1'b0;
    wr(REG_FAST, 8'h33);
    safeGood = 1'b1;
    repeat (4) @(negedge ref_clk);
    rdChk(REG_CTRL, 8'h00);
    rdChk(REG_FAST, 8'h4A);
    // A level held high must not keep clearing
    wr(REG_INLIM, 8'h05);
    rdChk(REG_INLIM, 8'h05);
    safeGood    = 1'b0;
    supplyValid = 1'b0;
    repeat (4) @(negedge ref_clk);
    supplyValid = 1'b1;
    repeat (4) @(negedge ref_clk);
    rdChk(REG_INLIM, 8'h14);
    chkNum(11'(sdaOut), 11'h000);
    end_of_test();
  end
endmodule // testbench
